// *** hw/lspd_scan_ctrl.sv ***
// Gate scan order, frame mark, partial display selection and gamma tune registers
`timescale 1ns/100ps
module lspd_scan_ctrl #(
	parameter int LINE_CYCLES = lspd_pkg::LINE_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [lspd_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lspd_pkg::DATA_W-1:0] pwdata,
	output logic [lspd_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic frame_mark_out,
	output logic [8:0] gate_line,
	output logic gate_strobe,
	output logic line_visible,
	output logic [8:0] source_row,
	output logic [lspd_pkg::GAMMA_N*lspd_pkg::GAMMA_SLOT-1:0] gamma_pos_tune,
	output logic [lspd_pkg::GAMMA_N*lspd_pkg::GAMMA_SLOT-1:0] gamma_neg_tune,
	output logic irq
);

	logic scan_interleave_sel_reg;
	logic gate_scan_direction_reg;
	logic base_image_enable_reg;
	logic partial_img1_enable_reg;
	logic partial_img2_enable_reg;
	logic [5:0] active_line_count_reg;
	logic [8:0] frame_mark_line_pos_reg;
	logic [2:0] frame_mark_interval_reg;
	logic [8:0] base_area_start_reg;
	logic [8:0] base_area_end_reg;
	logic [8:0] partial_img1_start_reg;
	logic [8:0] partial_img1_end_reg;
	logic [8:0] partial_img2_start_reg;
	logic [8:0] partial_img2_end_reg;
	logic [8:0] partial_img1_screen_pos_reg;
	logic [8:0] partial_img2_screen_pos_reg;
	logic [5:0] gamma_pos_reg [lspd_pkg::GAMMA_N];
	logic [5:0] gamma_neg_reg [lspd_pkg::GAMMA_N];
	logic [lspd_pkg::IRQ_N-1:0] irq_stat_reg;
	logic [lspd_pkg::IRQ_N-1:0] irq_mask_reg;
	logic [lspd_pkg::DATA_W-1:0] prdata_reg;
	logic pslverr_reg;
	logic [15:0] div_reg;
	logic [9:0] step_reg;
	logic [2:0] skip_reg;
	logic frame_mark_reg;
	logic [8:0] gate_line_reg;
	logic gate_strobe_reg;
	logic line_visible_reg;
	logic [8:0] source_row_reg;

	logic [9:0] idx;
	logic wr_en;
	logic setup;
	logic mapped;
	logic [lspd_pkg::DATA_W-1:0] rd_next;
	logic line_tick;
	logic [9:0] lines_next;
	logic [9:0] half;
	logic [9:0] gate_next;
	logic last_step;
	logic fm_hit;
	logic vis_next;
	logic [9:0] row_next;
	logic [9:0] scr;
	logic [lspd_pkg::IRQ_N-1:0] irq_evt;

	assign idx = paddr[lspd_pkg::ADDR_W-1:2];
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	// Address decode
	always_comb begin
		mapped = 1'b1;
		rd_next = '0;
		case (idx)
			lspd_pkg::IDX_CTRL: begin
				rd_next[lspd_pkg::CTRL_SM] = scan_interleave_sel_reg;
				rd_next[lspd_pkg::CTRL_GS] = gate_scan_direction_reg;
				rd_next[lspd_pkg::CTRL_BASE] = base_image_enable_reg;
				rd_next[lspd_pkg::CTRL_P1] = partial_img1_enable_reg;
				rd_next[lspd_pkg::CTRL_P2] = partial_img2_enable_reg;
				rd_next[lspd_pkg::CTRL_NL +: 6] = active_line_count_reg;
			end
			lspd_pkg::IDX_FRAME_MARK_OUT: begin
				rd_next[lspd_pkg::FM_POS +: 9] = frame_mark_line_pos_reg;
				rd_next[lspd_pkg::FM_INT +: 3] = frame_mark_interval_reg;
			end
			lspd_pkg::IDX_BASE: begin
				rd_next[lspd_pkg::LO_F +: 9] = base_area_start_reg;
				rd_next[lspd_pkg::HI_F +: 9] = base_area_end_reg;
			end
			lspd_pkg::IDX_PI1_AREA: begin
				rd_next[lspd_pkg::LO_F +: 9] = partial_img1_start_reg;
				rd_next[lspd_pkg::HI_F +: 9] = partial_img1_end_reg;
			end
			lspd_pkg::IDX_PI2_AREA: begin
				rd_next[lspd_pkg::LO_F +: 9] = partial_img2_start_reg;
				rd_next[lspd_pkg::HI_F +: 9] = partial_img2_end_reg;
			end
			lspd_pkg::IDX_PI_POS: begin
				rd_next[lspd_pkg::LO_F +: 9] = partial_img1_screen_pos_reg;
				rd_next[lspd_pkg::HI_F +: 9] = partial_img2_screen_pos_reg;
			end
			lspd_pkg::IDX_STATUS: begin
				rd_next[lspd_pkg::ST_LINE +: 9] = gate_line_reg;
				rd_next[lspd_pkg::ST_FRAME_MARK_OUT] = frame_mark_reg;
				rd_next[lspd_pkg::ST_SCAN +: 10] = step_reg;
			end
			lspd_pkg::IDX_IRQ_STAT: begin
				rd_next[lspd_pkg::IRQ_N-1:0] = irq_stat_reg;
			end
			lspd_pkg::IDX_IRQ_MASK: begin
				rd_next[lspd_pkg::IRQ_N-1:0] = irq_mask_reg;
			end
			default: begin
				// Gamma window; unused slots read zero
				if (idx >= lspd_pkg::IDX_GAMMA_FIRST && idx <= lspd_pkg::IDX_GAMMA_LAST) begin
					if (idx[9:4] == lspd_pkg::IDX_GAMMA_POS[9:4]) begin
						rd_next[5:0] = gamma_pos_reg[idx[3:0]];
					end else if (idx[9:4] == lspd_pkg::IDX_GAMMA_NEG[9:4]) begin
						rd_next[5:0] = gamma_neg_reg[idx[3:0]];
					end
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
	end

	// Read data and error captured in setup phase
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= pwrite ? '0 : rd_next;
			pslverr_reg <= !mapped;
		end
	end

	// Control and mode registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scan_interleave_sel_reg <= 1'b0;
			gate_scan_direction_reg <= 1'b0;
			base_image_enable_reg <= 1'b1;
			partial_img1_enable_reg <= 1'b0;
			partial_img2_enable_reg <= 1'b0;
			active_line_count_reg <= lspd_pkg::NL_RESET;
			frame_mark_line_pos_reg <= lspd_pkg::FM_POS_RESET;
			frame_mark_interval_reg <= lspd_pkg::FM_INT_RESET;
		end else if (wr_en && idx == lspd_pkg::IDX_CTRL) begin
			scan_interleave_sel_reg <= pwdata[lspd_pkg::CTRL_SM];
			gate_scan_direction_reg <= pwdata[lspd_pkg::CTRL_GS];
			base_image_enable_reg <= pwdata[lspd_pkg::CTRL_BASE];
			partial_img1_enable_reg <= pwdata[lspd_pkg::CTRL_P1];
			partial_img2_enable_reg <= pwdata[lspd_pkg::CTRL_P2];
			active_line_count_reg <= pwdata[lspd_pkg::CTRL_NL +: 6];
		end else if (wr_en && idx == lspd_pkg::IDX_FRAME_MARK_OUT) begin
			frame_mark_line_pos_reg <= pwdata[lspd_pkg::FM_POS +: 9];
			frame_mark_interval_reg <= pwdata[lspd_pkg::FM_INT +: 3];
		end
	end

	// Display area registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			base_area_start_reg <= '0;
			base_area_end_reg <= lspd_pkg::BASE_END_RESET;
			partial_img1_start_reg <= '0;
			partial_img1_end_reg <= '0;
			partial_img2_start_reg <= '0;
			partial_img2_end_reg <= '0;
			partial_img1_screen_pos_reg <= '0;
			partial_img2_screen_pos_reg <= '0;
		end else if (wr_en) begin
			if (idx == lspd_pkg::IDX_BASE) begin
				base_area_start_reg <= pwdata[lspd_pkg::LO_F +: 9];
				base_area_end_reg <= pwdata[lspd_pkg::HI_F +: 9];
			end
			if (idx == lspd_pkg::IDX_PI1_AREA) begin
				partial_img1_start_reg <= pwdata[lspd_pkg::LO_F +: 9];
				partial_img1_end_reg <= pwdata[lspd_pkg::HI_F +: 9];
			end
			if (idx == lspd_pkg::IDX_PI2_AREA) begin
				partial_img2_start_reg <= pwdata[lspd_pkg::LO_F +: 9];
				partial_img2_end_reg <= pwdata[lspd_pkg::HI_F +: 9];
			end
			if (idx == lspd_pkg::IDX_PI_POS) begin
				partial_img1_screen_pos_reg <= pwdata[lspd_pkg::LO_F +: 9];
				partial_img2_screen_pos_reg <= pwdata[lspd_pkg::HI_F +: 9];
			end
		end
	end

	// Gamma fine-tune fields, masked to their widths
	generate
		for (genvar i = 0; i < lspd_pkg::GAMMA_N; i++) begin : g_gamma
			localparam logic [5:0] MASK = 6'((1 << lspd_pkg::GAMMA_W[i]) - 1);
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					gamma_pos_reg[i] <= '0;
					gamma_neg_reg[i] <= '0;
				end else if (wr_en) begin
					if (idx == lspd_pkg::IDX_GAMMA_POS + 10'(i)) begin
						gamma_pos_reg[i] <= pwdata[5:0] & MASK;
					end
					if (idx == lspd_pkg::IDX_GAMMA_NEG + 10'(i)) begin
						gamma_neg_reg[i] <= pwdata[5:0] & MASK;
					end
				end
			end
			assign gamma_pos_tune[i*lspd_pkg::GAMMA_SLOT +: lspd_pkg::GAMMA_SLOT] = gamma_pos_reg[i];
			assign gamma_neg_tune[i*lspd_pkg::GAMMA_SLOT +: lspd_pkg::GAMMA_SLOT] = gamma_neg_reg[i];
		end
	endgenerate

	// Line rate divider
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
		end else if (div_reg == 16'(LINE_CYCLES - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end
	assign line_tick = (div_reg == 16'(LINE_CYCLES - 1));

	// Active lines: eight per count step, full panel at 6'h35 and up
	always_comb begin
		if (active_line_count_reg >= lspd_pkg::NL_FULL) begin
			lines_next = lspd_pkg::LINES_MAX;
		end else begin
			lines_next = {1'b0, active_line_count_reg + 6'h01, 3'h0};
		end
	end
	assign half = {1'b0, lines_next[9:1]};
	assign last_step = (step_reg >= lines_next - 10'h001);

	// Gate line for the current scan step
	always_comb begin
		case ({scan_interleave_sel_reg, gate_scan_direction_reg})
			2'b00: begin
				gate_next = step_reg + 10'h001;
			end
			2'b01: begin
				gate_next = lines_next - step_reg;
			end
			2'b10: begin
				if (step_reg < half) begin
					gate_next = {step_reg[8:0], 1'b1};
				end else begin
					gate_next = 10'({step_reg - half, 1'b0}) + 10'h002;
				end
			end
			2'b11: begin
				if (step_reg < half) begin
					gate_next = lines_next - {step_reg[8:0], 1'b0};
				end else begin
					gate_next = lines_next - 10'h001 - 10'({step_reg - half, 1'b0});
				end
			end
			default: begin
				gate_next = step_reg + 10'h001;
			end
		endcase
	end

	// Visibility and source row of the scanned screen line
	always_comb begin
		scr = gate_next - 10'h001;
		vis_next = 1'b0;
		row_next = scr;
		if (base_image_enable_reg) begin
			vis_next = (scr >= {1'b0, base_area_start_reg}) && (scr <= {1'b0, base_area_end_reg});
		end else begin
			// Image 2 first so image 1 wins an overlap
			if (partial_img2_enable_reg && scr >= {1'b0, partial_img2_screen_pos_reg}
				&& scr - {1'b0, partial_img2_screen_pos_reg}
				<= {1'b0, partial_img2_end_reg} - {1'b0, partial_img2_start_reg}) begin
				vis_next = 1'b1;
				row_next = {1'b0, partial_img2_start_reg} + scr - {1'b0, partial_img2_screen_pos_reg};
			end
			if (partial_img1_enable_reg && scr >= {1'b0, partial_img1_screen_pos_reg}
				&& scr - {1'b0, partial_img1_screen_pos_reg}
				<= {1'b0, partial_img1_end_reg} - {1'b0, partial_img1_start_reg}) begin
				vis_next = 1'b1;
				row_next = {1'b0, partial_img1_start_reg} + scr - {1'b0, partial_img1_screen_pos_reg};
			end
		end
	end

	// Scan step counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_reg <= '0;
		end else if (line_tick) begin
			step_reg <= last_step ? 10'h000 : step_reg + 10'h001;
		end
	end

	// Gate outputs, registered per line
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			gate_line_reg <= '0;
			gate_strobe_reg <= 1'b0;
			line_visible_reg <= 1'b0;
			source_row_reg <= '0;
		end else begin
			gate_strobe_reg <= line_tick;
			if (line_tick) begin
				gate_line_reg <= gate_next[8:0];
				line_visible_reg <= vis_next;
				source_row_reg <= row_next[8:0];
			end
		end
	end

	// Frame skip counter for the mark interval
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			skip_reg <= '0;
		end else if (line_tick && last_step) begin
			skip_reg <= (skip_reg == 3'h0) ? frame_mark_interval_reg : skip_reg - 3'h1;
		end
	end
	assign fm_hit = (step_reg == {1'b0, frame_mark_line_pos_reg}) && (skip_reg == 3'h0);

	// Frame mark held for one line period
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			frame_mark_reg <= 1'b0;
		end else if (line_tick) begin
			frame_mark_reg <= fm_hit;
		end
	end

	// Interrupt status, set wins over clear
	assign irq_evt = {line_tick && last_step, line_tick && fm_hit};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			if (wr_en && idx == lspd_pkg::IDX_IRQ_MASK) begin
				irq_mask_reg <= pwdata[lspd_pkg::IRQ_N-1:0];
			end
			if (wr_en && idx == lspd_pkg::IDX_IRQ_STAT) begin
				irq_stat_reg <= (irq_stat_reg & ~pwdata[lspd_pkg::IRQ_N-1:0]) | irq_evt;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_evt;
			end
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);
	assign frame_mark_out = frame_mark_reg;
	assign gate_line = gate_line_reg;
	assign gate_strobe = gate_strobe_reg;
	assign line_visible = line_visible_reg;
	assign source_row = source_row_reg;

endmodule

// *** inc/lspd_pkg.sv ***
// Constants for the scan, partial display and gamma register block
package lspd_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CTRL = 10'h000;
	localparam logic [9:0] IDX_FRAME_MARK_OUT = 10'h001;
	localparam logic [9:0] IDX_BASE = 10'h002;
	localparam logic [9:0] IDX_PI1_AREA = 10'h003;
	localparam logic [9:0] IDX_PI2_AREA = 10'h004;
	localparam logic [9:0] IDX_PI_POS = 10'h005;
	localparam logic [9:0] IDX_STATUS = 10'h006;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h007;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h008;
	localparam logic [9:0] IDX_GAMMA_FIRST = 10'h300;
	localparam logic [9:0] IDX_GAMMA_LAST = 10'h3f0;
	localparam logic [9:0] IDX_GAMMA_POS = 10'h300;
	localparam logic [9:0] IDX_GAMMA_NEG = 10'h310;
	// Control fields
	localparam int CTRL_SM = 0;
	localparam int CTRL_GS = 1;
	localparam int CTRL_BASE = 2;
	localparam int CTRL_P1 = 3;
	localparam int CTRL_P2 = 4;
	localparam int CTRL_NL = 8;
	localparam int FM_POS = 0;
	localparam int FM_INT = 16;
	// Start or image 1 position field low, end or image 2 position field high
	localparam int LO_F = 0;
	localparam int HI_F = 16;
	localparam int ST_LINE = 0;
	localparam int ST_FRAME_MARK_OUT = 16;
	localparam int ST_SCAN = 17;
	// Interrupt bits
	localparam int IRQ_N = 2;
	localparam int IRQ_FRAME_MARK_OUT = 0;
	localparam int IRQ_FRAME = 1;
	// Reset values and full panel line count limits
	localparam logic [5:0] NL_RESET = 6'h35;
	localparam logic [5:0] NL_FULL = 6'h35;
	localparam logic [9:0] LINES_MAX = 10'h1b0;
	localparam logic [8:0] BASE_END_RESET = 9'h1af;
	localparam logic [8:0] FM_POS_RESET = 9'h000;
	localparam logic [2:0] FM_INT_RESET = 3'h0;
	// Gamma fine-tune fields
	localparam int GAMMA_N = 16;
	localparam int GAMMA_SLOT = 6;
	localparam int GAMMA_W [GAMMA_N] = '{5, 6, 6, 6, 6, 5, 5, 5, 4, 4, 4, 4, 4, 4, 4, 4};
	// Grayscale level tuned by each field
	localparam int GAMMA_LEVEL [GAMMA_N] = '{0, 1, 2, 61, 62, 63, 13, 50, 4, 8, 20, 27, 36, 43, 55, 59};
	// Line period in clock cycles
	localparam int LINE_CYCLES_DEF = 64;
endpackage

// *** tb/lspd_host_model.sv ***
// Host model issuing APB transfers to the register port
`timescale 1ns/100ps
module lspd_host_model (
	input wire logic clock,
	input wire logic [lspd_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic [lspd_pkg::ADDR_W-1:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [lspd_pkg::DATA_W-1:0] pwdata
);
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= '0;
		pwdata <= '0;
	end
	// One transfer: setup, then access until ready
	task automatic xfer(input logic [9:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clock);
		paddr <= {idx, 2'b00};
		pwrite <= wr;
		pwdata <= wd;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines carry no stale value
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule

// *** tb/lspd_scan_ctrl_asserts.sv ***
// Port checker for the scan control block
`timescale 1ns/100ps
module lspd_scan_ctrl_asserts #(
	parameter int LINE_CYCLES = lspd_pkg::LINE_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [lspd_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic frame_mark_out,
	input wire logic [8:0] gate_line,
	input wire logic gate_strobe,
	input wire logic line_visible
);
	logic [9:0] idx;
	logic [9:0] cnt_reg;
	logic seen_reg;
	assign idx = paddr[11:2];
	// Cycles since the last line strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= 10'h000;
			seen_reg <= 1'b0;
		end else if (gate_strobe) begin
			cnt_reg <= 10'h000;
			seen_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 10'h001;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_period;
		gate_strobe && seen_reg |-> cnt_reg == LINE_CYCLES - 1;
	endproperty
	property p_pulse;
		gate_strobe |=> !gate_strobe;
	endproperty
	property p_line_hold;
		$changed(gate_line) |-> gate_strobe;
	endproperty
	property p_vis_hold;
		$changed(line_visible) |-> gate_strobe;
	endproperty
	property p_fm;
		$changed(frame_mark_out) |-> gate_strobe;
	endproperty
	property p_limit;
		gate_strobe |-> gate_line != 9'h000 && gate_line <= 9'h1b0;
	endproperty
	property p_err;
		psel && penable && ((idx > 10'h008 && idx < 10'h300) || idx > 10'h3f0) |-> pslverr;
	endproperty
	property p_noerr;
		psel && penable && (idx <= 10'h008 || (idx >= 10'h300 && idx <= 10'h3f0)) |-> !pslverr;
	endproperty
	a_period: assert property (p_period) else $error("line period wrong");
	a_pulse: assert property (p_pulse) else $error("strobe too long");
	a_line_hold: assert property (p_line_hold) else $error("line moved off strobe");
	a_vis_hold: assert property (p_vis_hold) else $error("visible moved off strobe");
	a_fm: assert property (p_fm) else $error("frame mark off line start");
	a_limit: assert property (p_limit) else $error("gate line out of range");
	a_err: assert property (p_err) else $error("missing slave error");
	a_noerr: assert property (p_noerr) else $error("spurious slave error");
	c_fm: cover property ($rose(frame_mark_out));
	c_err: cover property (psel && penable && pslverr);
	c_vis: cover property ($rose(line_visible));
endmodule
bind lspd_scan_ctrl lspd_scan_ctrl_asserts #(.LINE_CYCLES(LINE_CYCLES)) lspd_scan_ctrl_asserts_i (.clock, .rst,
	.paddr, .psel, .penable, .pslverr, .frame_mark_out, .gate_line, .gate_strobe, .line_visible);

// *** tb/lspd_scan_ctrl_tb.sv ***
// Self-checking bench for the scan control block
`timescale 1ns/100ps
module lspd_scan_ctrl_tb;
	localparam int LC = 4;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [lspd_pkg::ADDR_W-1:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [lspd_pkg::DATA_W-1:0] pwdata;
	logic [lspd_pkg::DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic frame_mark_out;
	logic [8:0] gate_line;
	logic gate_strobe;
	logic line_visible;
	logic [8:0] source_row;
	logic [lspd_pkg::GAMMA_N*lspd_pkg::GAMMA_SLOT-1:0] gamma_pos_tune;
	logic [lspd_pkg::GAMMA_N*lspd_pkg::GAMMA_SLOT-1:0] gamma_neg_tune;
	logic irq;
	logic [31:0] rd;
	logic er;
	logic [31:0] gm;
	logic [9:0] e;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int marks;
	int cs [6] = '{4, 8, 16, 24, 28, 0};
	lspd_scan_ctrl #(.LINE_CYCLES(LC)) lspd_scan_ctrl_i (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .frame_mark_out, .gate_line, .gate_strobe, .line_visible, .source_row,
		.gamma_pos_tune, .gamma_neg_tune, .irq);
	lspd_host_model lspd_host_model_i (.clock, .prdata, .pready, .pslverr, .paddr, .psel, .penable, .pwrite,
		.pwdata);
	always #20 clock = ~clock;
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles > 30000) begin
			miscompares++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xf(input logic [9:0] idx, input logic wr, input logic [31:0] d);
		lspd_host_model_i.xfer(idx, wr, d, rd, er);
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [31:0] x, input logic xe);
		xf(idx, 1'b0, 32'h0);
		chk(rd, x);
		chk({31'h0, er}, {31'h0, xe});
	endtask
	task automatic ws;
		do @(negedge clock); while (gate_strobe !== 1'b1);
	endtask
	// Gate line at scan step s for an eight line frame
	function automatic int gl(int m, int s);
		case (m)
			0: return s + 1;
			1: return s < 4 ? 2 * s + 1 : 2 * s - 6;
			2: return 8 - s;
			default: return s < 4 ? 8 - 2 * s : 15 - 2 * s;
		endcase
	endfunction
	// Visible flag and source row for gate line g
	function automatic logic [9:0] ex(int c, int g);
		if (c[2]) return {g >= 3 && g <= 5, 9'(g - 1)};
		if (c[3] && g <= 2) return {1'b1, 9'(g + 9)};
		if (c[4] && g == 6) return 10'h214;
		return 10'h000;
	endfunction
	task automatic scan(input int m);
		xf(10'h000, 1'b1, 32'h4 | m);
		repeat (2) ws;
		do ws; while (gate_line !== 9'(gl(m, 0)));
		for (int s = 0; s < 8; s++) begin
			chk(gate_line, gl(m, s));
			ws;
		end
	endtask
	task automatic vis(input int c);
		xf(10'h000, 1'b1, c);
		repeat (2) ws;
		do ws; while (gate_line !== 9'h001);
		for (int g = 1; g <= 8; g++) begin
			e = ex(c, g);
			chk(line_visible, e[9]);
			if (e[9]) chk(source_row, e[8:0]);
			ws;
		end
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (250) @(posedge clock);
		rdc(10'h000, 32'h0000_3504, 1'b0);
		rdc(10'h002, 32'h01af_0000, 1'b0);
		rdc(10'h009, 32'h0, 1'b1);
		xf(10'h3f0, 1'b1, '1);
		rdc(10'h3f0, 32'h0, 1'b0);
		for (int i = 0; i < 16; i++) begin
			xf(10'(10'h300 + i), 1'b1, '1);
			xf(10'(10'h310 + i), 1'b1, 32'h15);
		end
		for (int i = 0; i < 16; i++) begin
			gm = (32'h1 << lspd_pkg::GAMMA_W[i]) - 32'h1;
			rdc(10'(10'h300 + i), gm, 1'b0);
			rdc(10'(10'h310 + i), gm & 32'h15, 1'b0);
			chk({26'h0, gamma_pos_tune[i*6 +: 6]}, gm);
			chk({26'h0, gamma_neg_tune[i*6 +: 6]}, gm & 32'h15);
		end
		for (int m = 0; m < 4; m++) scan(m);
		xf(10'h001, 1'b1, 32'h0001_0003);
		xf(10'h000, 1'b1, 32'h4);
		repeat (16) ws;
		marks = 0;
		repeat (64) begin
			ws;
			if (frame_mark_out === 1'b1) begin
				marks++;
				chk(gate_line, 4);
			end
		end
		chk(marks, 4);
		xf(10'h001, 1'b1, 32'h0007_0000);
		xf(10'h002, 1'b1, 32'h0004_0002);
		xf(10'h003, 1'b1, 32'h000b_000a);
		xf(10'h004, 1'b1, 32'h0014_0014);
		xf(10'h005, 1'b1, 32'h0005_0000);
		for (int k = 0; k < 6; k++) vis(cs[k]);
		xf(10'h008, 1'b1, 32'h0);
		do @(negedge clock); while (frame_mark_out !== 1'b1);
		chk(irq, 1'b0);
		xf(10'h007, 1'b0, 32'h0);
		chk(rd[0], 1'b1);
		xf(10'h008, 1'b1, 32'h1);
		@(negedge clock);
		chk(irq, 1'b1);
		xf(10'h007, 1'b1, 32'h1);
		@(negedge clock);
		chk(irq, 1'b0);
		xf(10'h008, 1'b1, 32'h2);
		@(negedge clock);
		chk(irq, 1'b1);
		xf(10'h008, 1'b1, 32'h0);
		final_report;
	end
endmodule
